//--- src/byte_bank.v
`include "regfile_regs.vh"

// One bank of eight byte registers: acc, flags and six general ones.
// Byte i lives at bank_flat[8*i+7:8*i]; pair p is bytes 2p (high), 2p+1 (low).
module byte_bank (
	input wire clk,
	input wire rst_n,
	input wire byte_we,
	input wire [2:0] byte_idx,
	input wire [7:0] byte_data,
	input wire pair_we,
	input wire [1:0] pair_idx,
	input wire [15:0] pair_data,
	output wire [63:0] bank_flat
);

	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_byte
			localparam [31:0] BI = i;
			localparam [31:0] PI = i / 2;
			reg [7:0] byte_ff;
			// A pair write wins over a byte write to the same byte
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					byte_ff <= `RST_BYTE;
				end else if (pair_we && pair_idx == PI[1:0]) begin // RL5
					byte_ff <= (i % 2 == 1) ? pair_data[7:0] : pair_data[15:8];
				end else if (byte_we && byte_idx == BI[2:0]) begin // RL5
					byte_ff <= byte_data;
				end
			end
			assign bank_flat[8*i+7:8*i] = byte_ff;
		end
	endgenerate

endmodule // byte_bank

//--- src/cpu_regfile_irq_state.v
`include "regfile_regs.vh"

// How it works
// RL1 - Enable flag zero blocks, one permits maskables
// RL2 - Non-maskable entry saves enable into saved flag
// RL3 - Two mode bits encode modes zero, one, two
// RL4 - Main and alternate banks swapped by exchanges
// RL5 - Byte access and fixed 16-bit pair access
// RL6 - Two index registers, stack pointer, program counter
// RL7 - Programmer storage totals 208 bits
// RL8 - Separate refresh counter and vector page registers
// RL9 - Refresh low seven bits count per fetch
// RL10 - Vector page supplies vectored address high byte
// RL11 - Bank swap is one atomic pointer flip
module cpu_regfile_irq_state (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire byte_wr_en,
	input wire [2:0] byte_wr_idx,
	input wire [7:0] byte_wr_data,
	input wire pair_wr_en,
	input wire [1:0] pair_wr_idx,
	input wire [15:0] pair_wr_data,
	input wire [2:0] byte_rd_idx,
	output reg [7:0] byte_rd_data,
	input wire [1:0] pair_rd_idx,
	output reg [15:0] pair_rd_data,
	input wire swap_af,
	input wire swap_gp,
	input wire word_wr_en,
	input wire [1:0] word_wr_idx,
	input wire [15:0] word_wr_data,
	input wire [1:0] word_rd_idx,
	output reg [15:0] word_rd_data,
	input wire pc_inc,
	input wire vec_wr_en,
	input wire [7:0] vec_wr_data,
	input wire rfsh_wr_en,
	input wire [7:0] rfsh_wr_data,
	input wire fetch_done,
	output wire [7:0] refresh_addr,
	output wire [7:0] vector_page,
	input wire ei_cmd,
	input wire di_cmd,
	input wire nmi_accept,
	input wire int_accept,
	input wire nmi_return,
	input wire im_set_en,
	input wire [1:0] im_value,
	input wire int_req,
	output wire int_take,
	output wire irq_enable_flag,
	output wire saved_enable_flag,
	output wire irq_mode_bit_first,
	output wire irq_mode_bit_second,
	output wire [1:0] irq_mode
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Acc and flags follow one bank pointer, the six general bytes the other
	function bank_of;
		input [2:0] idx;
		input af_sel;
		input gp_sel;
		begin
			bank_of = (idx[2:1] == 2'b00) ? af_sel : gp_sel;
		end
	endfunction

	function [7:0] byte_pick;
		input [63:0] flat;
		input [2:0] idx;
		begin
			byte_pick = flat[{idx, 3'b000} +: 8];
		end
	endfunction

	// ----------------------------------------------------------------
	// State flip-flops
	// ----------------------------------------------------------------
	reg ien_ff, sen_ff, ima_ff, imb_ff, afb_ff, gpb_ff;
	reg nxt_ien, nxt_sen, nxt_ima, nxt_imb, nxt_afb, nxt_gpb;
	reg [15:0] bx_ff, by_ff, sp_ff, pc_ff;
	reg [7:0] vec_ff, rfsh_ff;
	wire [63:0] flat0;
	wire [63:0] flat1;
	wire setup_ph;
	wire access_ph;
	reg addr_hit;
	reg [31:0] nxt_prdata;
	wire state_wr;

	assign setup_ph = psel & ~penable;
	assign access_ph = psel & penable;
	assign state_wr = access_ph & pwrite & addr_hit & (paddr == `OFF_STATE);

	// ----------------------------------------------------------------
	// Banked byte registers
	// ----------------------------------------------------------------
	// 2 banks x 8 bytes (128) + four words (64) + vector and refresh (16)
	genvar b;
	generate
		for (b = 0; b < 2; b = b + 1) begin : g_bank // RL7
			wire hit_byte = (bank_of(byte_wr_idx, afb_ff, gpb_ff) == (b == 1));
			wire hit_pair = (bank_of({pair_wr_idx, 1'b0}, afb_ff, gpb_ff) == (b == 1));
			wire [63:0] flat;
			byte_bank u_bank (
				.clk(pclk),
				.rst_n(presetn),
				.byte_we(byte_wr_en & hit_byte), // RL4
				.byte_idx(byte_wr_idx),
				.byte_data(byte_wr_data),
				.pair_we(pair_wr_en & hit_pair), // RL4
				.pair_idx(pair_wr_idx),
				.pair_data(pair_wr_data),
				.bank_flat(flat)
			);
		end
	endgenerate
	assign flat0 = g_bank[0].flat;
	assign flat1 = g_bank[1].flat;

	// Reads see the stored state before any write or swap of this cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			byte_rd_data <= `RST_BYTE;
			pair_rd_data <= `RST_WORD;
		end else begin
			byte_rd_data <= bank_of(byte_rd_idx, afb_ff, gpb_ff) ?
				byte_pick(flat1, byte_rd_idx) : byte_pick(flat0, byte_rd_idx); // RL4
			pair_rd_data <= bank_of({pair_rd_idx, 1'b0}, afb_ff, gpb_ff) ?
				{byte_pick(flat1, {pair_rd_idx, 1'b0}),
				byte_pick(flat1, {pair_rd_idx, 1'b1})} :
				{byte_pick(flat0, {pair_rd_idx, 1'b0}),
				byte_pick(flat0, {pair_rd_idx, 1'b1})}; // RL5
		end
	end

	// ----------------------------------------------------------------
	// Word registers, vector page and refresh counter
	// ----------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bx_ff <= `RST_WORD;
			by_ff <= `RST_WORD;
			sp_ff <= `RST_SP;
			pc_ff <= `RST_WORD;
			word_rd_data <= `RST_WORD;
		end else begin
			if (word_wr_en && word_wr_idx == `WORD_BX) begin // RL6
				bx_ff <= word_wr_data;
			end
			if (word_wr_en && word_wr_idx == `WORD_BY) begin // RL6
				by_ff <= word_wr_data;
			end
			if (word_wr_en && word_wr_idx == `WORD_SP) begin // RL6
				sp_ff <= word_wr_data;
			end
			// A load of the program counter wins over its increment
			if (word_wr_en && word_wr_idx == `WORD_PC) begin // RL6
				pc_ff <= word_wr_data;
			end else if (pc_inc) begin
				pc_ff <= pc_ff + 16'h0001;
			end
			case (word_rd_idx)
				`WORD_BX: word_rd_data <= bx_ff;
				`WORD_BY: word_rd_data <= by_ff;
				`WORD_SP: word_rd_data <= sp_ff;
				default: word_rd_data <= pc_ff;
			endcase
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vec_ff <= `RST_BYTE;
			rfsh_ff <= `RST_BYTE;
		end else begin
			if (vec_wr_en) begin // RL8
				vec_ff <= vec_wr_data;
			end
			// Bit 7 only changes by an explicit load; it never carries
			if (rfsh_wr_en) begin // RL8
				rfsh_ff <= rfsh_wr_data;
			end else if (fetch_done) begin // RL9
				rfsh_ff <= {rfsh_ff[7], rfsh_ff[6:0] + 7'h01};
			end
		end
	end

	assign refresh_addr = rfsh_ff; // RL9
	assign vector_page = vec_ff; // RL10

	// ----------------------------------------------------------------
	// Interrupt and bank state
	// ----------------------------------------------------------------
	// Software writes land first; decoder events of the same cycle override
	always @* begin
		nxt_ien = ien_ff;
		nxt_sen = sen_ff;
		nxt_ima = ima_ff;
		nxt_imb = imb_ff;
		nxt_afb = afb_ff;
		nxt_gpb = gpb_ff;
		if (state_wr) begin
			nxt_ien = pwdata[`ST_IEN];
			nxt_sen = pwdata[`ST_SEN];
			nxt_ima = pwdata[`ST_IMA];
			nxt_imb = pwdata[`ST_IMB];
			nxt_afb = pwdata[`ST_AFB];
			nxt_gpb = pwdata[`ST_GPB];
		end
		// Swapping is a pointer flip, so no read sees half a bank
		if (swap_af) begin
			nxt_afb = ~afb_ff; // RL11
		end
		if (swap_gp) begin
			nxt_gpb = ~gpb_ff; // RL11
		end
		if (nmi_accept) begin
			nxt_sen = ien_ff; // RL2
			nxt_ien = 1'b0;
		end else if (int_accept) begin
			nxt_ien = 1'b0;
			nxt_sen = 1'b0;
		end else if (ei_cmd) begin
			nxt_ien = 1'b1;
			nxt_sen = 1'b1;
		end else if (di_cmd) begin
			nxt_ien = 1'b0;
			nxt_sen = 1'b0;
		end else if (nmi_return) begin
			nxt_ien = sen_ff; // RL2
		end
		// Value 3 is not a mode; the request keeps the old mode bits, even over a software write
		if (im_set_en) begin
			case (im_value)
				2'd0: begin
					nxt_ima = 1'b0; // RL3
					nxt_imb = 1'b0;
				end
				2'd1: begin
					nxt_ima = 1'b1; // RL3
					nxt_imb = 1'b0;
				end
				2'd2: begin
					nxt_ima = 1'b1; // RL3
					nxt_imb = 1'b1;
				end
				default: begin
					nxt_ima = ima_ff;
					nxt_imb = imb_ff;
				end
			endcase
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ien_ff <= 1'b0;
			sen_ff <= 1'b0;
			ima_ff <= 1'b0;
			imb_ff <= 1'b0;
			afb_ff <= 1'b0;
			gpb_ff <= 1'b0;
		end else begin
			ien_ff <= nxt_ien;
			sen_ff <= nxt_sen;
			ima_ff <= nxt_ima;
			imb_ff <= nxt_imb;
			afb_ff <= nxt_afb;
			gpb_ff <= nxt_gpb;
		end
	end

	assign int_take = int_req & ien_ff; // RL1
	assign irq_enable_flag = ien_ff;
	assign saved_enable_flag = sen_ff;
	assign irq_mode_bit_first = ima_ff;
	assign irq_mode_bit_second = imb_ff;
	// The unused 01 code reads back as mode 0
	assign irq_mode = (ima_ff & imb_ff) ? 2'd2 : (ima_ff ? 2'd1 : 2'd0); // RL3

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	always @* begin
		addr_hit = 1'b1;
		nxt_prdata = `RST_DATA;
		if (paddr == `OFF_STATE) begin
			nxt_prdata = {26'h000_0000, gpb_ff, afb_ff, imb_ff, ima_ff, sen_ff, ien_ff};
		end else if (paddr == `OFF_ACT_LO) begin
			nxt_prdata = {afb_ff ? flat1[15:0] : flat0[15:0],
				gpb_ff ? flat1[31:16] : flat0[31:16]};
		end else if (paddr == `OFF_ACT_HI) begin
			nxt_prdata = gpb_ff ? flat1[63:32] : flat0[63:32];
		end else if (paddr == `OFF_ALT_LO) begin
			nxt_prdata = {afb_ff ? flat0[15:0] : flat1[15:0],
				gpb_ff ? flat0[31:16] : flat1[31:16]};
		end else if (paddr == `OFF_ALT_HI) begin
			nxt_prdata = gpb_ff ? flat0[63:32] : flat1[63:32];
		end else if (paddr == `OFF_INDEX) begin
			nxt_prdata = {bx_ff, by_ff};
		end else if (paddr == `OFF_SPPC) begin
			nxt_prdata = {sp_ff, pc_ff};
		end else if (paddr == `OFF_VECRF) begin
			nxt_prdata = {16'h0000, vec_ff, rfsh_ff};
		end else begin
			addr_hit = 1'b0;
		end
	end

	// Read data is captured in the setup cycle so it comes from a flop
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `RST_DATA;
		end else if (setup_ph) begin
			prdata <= nxt_prdata;
		end
	end

	assign pready = 1'b1;
	assign pslverr = access_ph & ~addr_hit;

endmodule // cpu_regfile_irq_state

//--- src/regfile_regs.vh
`ifndef REGFILE_REGS_VH
`define REGFILE_REGS_VH

// ----------------------------------------------------------------
// APB word offsets (byte addresses)
// ----------------------------------------------------------------
`define OFF_STATE 8'h00
`define OFF_ACT_LO 8'h04
`define OFF_ACT_HI 8'h08
`define OFF_ALT_LO 8'h0C
`define OFF_ALT_HI 8'h10
`define OFF_INDEX 8'h14
`define OFF_SPPC 8'h18
`define OFF_VECRF 8'h1C

// ----------------------------------------------------------------
// State word bit positions
// ----------------------------------------------------------------
`define ST_IEN 0
`define ST_SEN 1
`define ST_IMA 2
`define ST_IMB 3
`define ST_AFB 4
`define ST_GPB 5

// ----------------------------------------------------------------
// Byte indices inside one bank, pair and word selectors
// ----------------------------------------------------------------
`define IDX_ACC 3'h0
`define IDX_FLG 3'h1
`define PAIR_AF 2'h0
`define WORD_BX 2'h0
`define WORD_BY 2'h1
`define WORD_SP 2'h2
`define WORD_PC 2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define RST_SP 16'hFFFF
`define RST_DATA 32'h0000_0000

`endif

//--- tb/cpu_regfile_irq_state_test.sv
module cpu_regfile_irq_state_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, int_req, pready, pslverr, se, int_take;
	logic [7:0] paddr, byte_rd_data, refresh_addr, vector_page;
	logic [31:0] pwdata, prdata, r;
	logic [9:0] p;
	logic [4:0] e;
	logic [2:0] idx, ri;
	logic [15:0] d, pair_rd_data, word_rd_data;
	logic [1:0] imv, irq_mode;
	logic ief, sef, mfa, mfb;
	int err_count, compares, i;
	decoder_model m (.pclk, .p, .e, .idx, .d, .imv, .ri);
	cpu_regfile_irq_state dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .byte_wr_en(e[0]), .byte_wr_idx(idx),
		.byte_wr_data(d[7:0]), .pair_wr_en(e[1]), .pair_wr_idx(idx[1:0]),
		.pair_wr_data(d), .byte_rd_idx(ri), .byte_rd_data, .pair_rd_idx(ri[1:0]),
		.pair_rd_data, .swap_af(p[0]), .swap_gp(p[1]), .word_wr_en(e[2]),
		.word_wr_idx(idx[1:0]), .word_wr_data(d), .word_rd_idx(ri[1:0]), .word_rd_data,
		.pc_inc(p[2]), .vec_wr_en(e[3]), .vec_wr_data(d[7:0]), .rfsh_wr_en(e[4]),
		.rfsh_wr_data(d[7:0]), .fetch_done(p[3]), .refresh_addr, .vector_page,
		.ei_cmd(p[4]), .di_cmd(p[5]), .nmi_accept(p[6]), .int_accept(p[7]),
		.nmi_return(p[8]), .im_set_en(p[9]), .im_value(imv), .int_req, .int_take,
		.irq_enable_flag(ief), .saved_enable_flag(sef), .irq_mode_bit_first(mfa),
		.irq_mode_bit_second(mfb), .irq_mode);
	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	initial begin
		pclk = 0;
		forever #4 pclk = ~pclk;
	end
	task chk(input [31:0] got, input [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task apb(input w, input [7:0] a, input [31:0] wd);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		se = pslverr;
		psel <= 0;
		penable <= 0;
		// Idle cycle so a following call never re-raises psel in the same step
		@(posedge pclk);
	endtask
	task rd(input [7:0] a, input [31:0] x);
		apb(0, a, 0);
		chk(r, x);
	endtask
	task wrap_up;
		$display("compares %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge pclk);
		err_count++;
		wrap_up;
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, int_req} = 0;
		err_count = 0;
		compares = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		rd(8'h18, 32'hFFFF_0000);
		rd(8'h20, 0);
		chk(se, 1);
		for (i = 0; i < 8; i++) m.wr(5'h01, i, 16'h0010 + i);
		rd(8'h04, 32'h1110_1312);
		m.wr(5'h02, 3, 16'hC0DE);
		rd(8'h08, 32'hDEC0_1514);
		m.look(1);
		chk(pair_rd_data, 16'h1213);
		chk(byte_rd_data, 8'h11);
		m.pulse(10'h001, 0);
		rd(8'h04, 32'h0000_1312);
		m.pulse(10'h003, 0);
		rd(8'h04, 32'h1110_0000);
		m.wr(5'h01, 2, 16'h00AB);
		m.pulse(10'h002, 0);
		rd(8'h04, 32'h1110_1312);
		rd(8'h0C, 32'h0000_00AB);
		for (i = 0; i < 4; i++) m.wr(5'h04, i, 16'h1234 * (i + 1));
		m.pulse(10'h004, 0);
		rd(8'h14, 32'h1234_2468);
		rd(8'h18, 32'h369C_48D1);
		chk(word_rd_data, 16'h2468);
		m.wr(5'h10, 0, 16'h00FF);
		m.wr(5'h08, 0, 16'h00A5);
		m.pulse(10'h008, 0);
		rd(8'h1C, 32'h0000_A580);
		chk(refresh_addr, 8'h80);
		chk(vector_page, 8'hA5);
		int_req <= 1;
		m.pulse(10'h010, 0);
		chk(int_take, 1);
		m.pulse(10'h040, 0);
		rd(8'h00, 2);
		chk(int_take, 0);
		m.pulse(10'h100, 0);
		rd(8'h00, 3);
		for (i = 0; i < 4; i++) begin
			m.pulse(10'h200, (i + 1) % 4);
			rd(8'h00, (i == 0) ? 7 : (i == 3) ? 3 : 15);
			chk(irq_mode, (i == 0) ? 1 : (i == 3) ? 0 : 2);
			chk({mfb, mfa, sef, ief}, (i == 0) ? 7 : (i == 3) ? 3 : 15);
		end
		apb(1, 8'h00, 32'h0000_0001);
		rd(8'h00, 1);
		m.pulse(10'h020, 0);
		rd(8'h00, 0);
		// Mid-run reset must bring SP, PC and the active high bytes back to their reset values
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		rd(8'h18, 32'hFFFF_0000);
		rd(8'h08, 0);
		wrap_up;
	end
endmodule // cpu_regfile_irq_state_test

//--- tb/decoder_model.sv
module decoder_model (
	input wire pclk,
	output logic [9:0] p,
	output logic [4:0] e,
	output logic [2:0] idx,
	output logic [15:0] d,
	output logic [1:0] imv,
	output logic [2:0] ri
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Strobes last one cycle, then a gap
	// ----------------------------------------
	initial begin
		p = 0;
		e = 0;
		idx = 0;
		d = 0;
		imv = 0;
		ri = 0;
	end
	task pulse(input [9:0] m, input [1:0] v);
		p <= m;
		imv <= v;
		@(posedge pclk);
		p <= 0;
		imv <= ~v;
		@(posedge pclk);
	endtask
	task wr(input [4:0] en, input [2:0] i, input [15:0] v);
		e <= en;
		idx <= i;
		d <= v;
		@(posedge pclk);
		e <= 0;
		// Stale data must not look valid
		d <= ~v;
		@(posedge pclk);
	endtask
	task look(input [2:0] i);
		ri <= i;
		repeat (2) @(posedge pclk);
	endtask
endmodule // decoder_model

//--- tb/regfile_chk_sva.sv
module regfile_chk (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire ei_cmd,
	input wire nmi_accept,
	input wire int_accept,
	input wire im_set_en,
	input wire [1:0] im_value,
	input wire int_req,
	input wire int_take,
	input wire irq_enable_flag,
	input wire saved_enable_flag,
	input wire irq_mode_bit_first,
	input wire irq_mode_bit_second,
	input wire [1:0] irq_mode,
	input wire fetch_done,
	input wire rfsh_wr_en,
	input wire [7:0] refresh_addr,
	input wire vec_wr_en,
	input wire [7:0] vec_wr_data,
	input wire [7:0] vector_page
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire st_wr = psel && penable && pwrite;
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	a_take_gate: assert property (int_take == (int_req && irq_enable_flag))
		else $error("take gate");
	a_ei_sets: assert property (ei_cmd && !nmi_accept && !int_accept
		|=> irq_enable_flag && saved_enable_flag) else $error("ei");
	a_nmi_save: assert property (nmi_accept |=> !irq_enable_flag
		&& saved_enable_flag == $past(irq_enable_flag)) else $error("nmi save");
	a_mode_decode: assert property (irq_mode == {irq_mode_bit_first
		& irq_mode_bit_second, irq_mode_bit_first & ~irq_mode_bit_second}) else $error("mode");
	a_mode_set: assert property (im_set_en && im_value != 2'd3 |=>
		irq_mode_bit_first == ($past(im_value) != 2'd0)
		&& irq_mode_bit_second == ($past(im_value) == 2'd2)) else $error("mode set");
	a_mode_hold: assert property (im_set_en && im_value == 2'd3 && !st_wr
		|=> $stable({irq_mode_bit_first, irq_mode_bit_second})) else $error("mode 3");
	a_rfsh_step: assert property (fetch_done && !rfsh_wr_en |=>
		refresh_addr == {$past(refresh_addr[7]), $past(refresh_addr[6:0]) + 7'h01})
		else $error("refresh");
	a_vec_load: assert property (vec_wr_en |=> vector_page == $past(vec_wr_data))
		else $error("vector");
	c_nmi: cover property (nmi_accept && irq_enable_flag);
	c_mode2: cover property (irq_mode == 2'd2);
	c_wrap: cover property (fetch_done && refresh_addr[6:0] == 7'h7F);
endmodule // regfile_chk

bind cpu_regfile_irq_state regfile_chk chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.ei_cmd, .nmi_accept, .int_accept, .im_set_en, .im_value, .int_req, .int_take,
	.irq_enable_flag, .saved_enable_flag, .irq_mode_bit_first, .irq_mode_bit_second,
	.irq_mode, .fetch_done, .rfsh_wr_en, .refresh_addr, .vec_wr_en, .vec_wr_data,
	.vector_page);
